/* crc_engine_defs.svh */
// Purpose: constants for the checksum engine
// Assumes: included by bare name
// Notes:   field positions refer to the setup control word, except the slot bits of the snooped address
`ifndef CRC_ENGINE_DEFS_SVH
`define CRC_ENGINE_DEFS_SVH

`define CRC_POLY32       32'h04C11DB7
`define CRC_SEED_RESET   32'hFFFFFFFF
`define CRC_POLY16_RESET 16'h1021
`define CTL_RESET        16'h0001

// setup control word fields
`define CTL_WIDE         0
`define CTL_BITREV_IN    1
`define CTL_BYTESWAP     2
`define CTL_RESREV_LSB   3
`define CTL_RESREV_MSB   4
`define CTL_SNOOP_EN     5
`define CTL_SNOOP_WR     6
`define CTL_SNOOP_RD     7
`define CTL_SLOT_LSB     8
`define CTL_SLOT_MSB     15

// block size codes
`define BLK_8            2'h0
`define BLK_16           2'h1
`define BLK_32           2'h2

// result reversal codes
`define RESREV_NONE      2'h0
`define RESREV_WORD      2'h1
`define RESREV_HALF      2'h2

// peripheral slot select in the snooped address
`define SLOT_ADDR_LSB    12
`define SLOT_ADDR_MSB    19

`endif

/* crc_engine_pkg.sv */
// Purpose: shared types of the checksum engine
// Assumes: nothing
// Notes:   numeric constants live in crc_engine_defs.svh
package crc_engine_pkg;
  typedef logic [1:0]  blk_size_t;
  typedef logic [1:0]  res_rev_t;
  typedef logic [31:0] word_t;

  typedef struct packed {
    blk_size_t size;
    word_t     data;
  } item_t;
endpackage : crc_engine_pkg

/* crc_stream_if.sv */
// Purpose: valid/ready stream of data items between engine stages
// Assumes: one clock domain
// Notes:   a transfer happens when valid and ready are both high
`timescale 1ns/100ps
interface crc_stream_if;
  logic                  valid;
  logic                  ready;
  crc_engine_pkg::item_t item;

  modport src (output valid, output item, input ready);
  modport snk (input valid, input item, output ready);
endinterface : crc_stream_if

/* crc_buffer2.sv */
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes:   full ready without a combinational path from the drain side
`timescale 1ns/100ps
module crc_buffer2 (
  input wire logic clk,        // clock
  input wire logic resetn,     // async reset, active low
  crc_stream_if.snk inPort,    // fill side
  crc_stream_if.src outPort    // drain side
);
  crc_engine_pkg::item_t slot_reg [0:1];
  logic                  wrPtr_reg;
  logic                  rdPtr_reg;
  logic [1:0]            count_reg;
  wire                   doPush;
  wire                   doPop;

  assign inPort.ready  = (count_reg != 2'h2);
  assign outPort.valid = (count_reg != 2'h0);
  assign outPort.item  = slot_reg[rdPtr_reg];
  assign doPush        = inPort.valid & inPort.ready;
  assign doPop         = outPort.valid & outPort.ready;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
    end else begin
      if (doPush) begin
        slot_reg[wrPtr_reg] <= inPort.item;
        wrPtr_reg           <= ~wrPtr_reg;
      end
      if (doPop) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      count_reg <= count_reg + {1'b0, doPush} - {1'b0, doPop};
    end
  end
endmodule : crc_buffer2

/* crc_engine.sv */
// Purpose: 16/32-bit checksum engine fed by firmware, DMA or bus snooping
// Assumes: runs on the peripheral bus clock; snooped bus is on the same clock
// Notes:
// Notes on behaviour
// - Wide mode uses the fixed polynomial 04C11DB7, not changeable by software.
// - Narrow mode uses a software-written 16-bit polynomial.
// - Every word written into the input port is folded into the checksum.
// - With snooping on, selected peripheral bus writes or reads are folded in unless the buffer is full.
// - Optional bit reversal inside each byte of incoming data.
// - Optional byte order reversal of each incoming word.
// - Result optionally bit reversed over the word or within each half-word.
// - One setup strobe loads the control word and the seed together; the narrow polynomial has its own write.
// - A block of 32, 16 or 8 bits is processed in one cycle, unrolled.
// - One 32-bit word per clock can be sustained.
// - DMA writes are accepted as input data, behind firmware and snooped words.
`timescale 1ns/100ps
`include "crc_engine_defs.svh"
module crc_engine (
  input  wire logic                        clk,          // peripheral bus clock
  input  wire logic                        resetn,       // async reset, active low
  input  wire logic                        setupValid,   // one-cycle setup strobe
  input  wire logic [15:0]                 setupCtrl,    // control word
  input  wire logic [31:0]                 setupSeed,    // seed of the remainder
  input  wire logic                        polyValid,    // one-cycle polynomial write
  input  wire logic [15:0]                 polyWord,     // narrow-mode polynomial
  input  wire logic                        fwValid,      // firmware data write
  input  wire crc_engine_pkg::item_t       fwItem,       // firmware data and size
  output wire logic                        fwReady,      // firmware write taken
  input  wire logic                        dmaValid,     // dma data write
  input  wire logic [31:0]                 dmaData,      // dma data word
  output wire logic                        dmaReady,     // dma write taken
  input  wire logic                        snoopSel,     // observed bus select
  input  wire logic                        snoopEnable,  // observed bus enable
  input  wire logic                        snoopReady,   // observed bus ready
  input  wire logic                        snoopWrite,   // observed bus direction
  input  wire logic [31:0]                 snoopAddr,    // observed bus address
  input  wire logic [31:0]                 snoopWdata,   // observed write data
  input  wire logic [31:0]                 snoopRdata,   // observed read data
  output logic      [31:0]                 result,       // checksum as presented
  output logic      [15:0]                 ctrlState,    // current control word
  output logic                             busy,         // buffered data pending
  output logic                             snoopLost     // pulse: snooped word dropped
);
  logic [31:0] crc_reg;
  logic [31:0] crc_next;
  logic [15:0] ctrl_reg;
  logic [15:0] poly_reg;
  logic        lost_reg;

  crc_stream_if fillIf ();
  crc_stream_if drainIf ();

  crc_buffer2 u_buffer (
    .clk     (clk),
    .resetn  (resetn),
    .inPort  (fillIf),
    .outPort (drainIf)
  );

  wire       wide     = ctrl_reg[`CTL_WIDE];
  wire       bitRevIn = ctrl_reg[`CTL_BITREV_IN];
  wire       byteSwap = ctrl_reg[`CTL_BYTESWAP];
  wire [1:0] resRev   = ctrl_reg[`CTL_RESREV_MSB:`CTL_RESREV_LSB];
  wire [7:0] slotSel  = ctrl_reg[`CTL_SLOT_MSB:`CTL_SLOT_LSB];

  // snoop: completed access phase to the selected peripheral slot
  wire slotHit  = (snoopAddr[`SLOT_ADDR_MSB:`SLOT_ADDR_LSB] == slotSel);
  wire dirHit   = snoopWrite ? ctrl_reg[`CTL_SNOOP_WR] : ctrl_reg[`CTL_SNOOP_RD];
  wire snoopHit = ctrl_reg[`CTL_SNOOP_EN] & snoopSel & snoopEnable & snoopReady
                  & slotHit & dirHit;
  wire [31:0] snoopWord = snoopWrite ? snoopWdata : snoopRdata;

  // the bus cannot be stalled, so snooped words win the buffer's fill side
  assign fwReady  = fillIf.ready & ~snoopHit;
  assign dmaReady = fillIf.ready & ~snoopHit & ~fwValid;
  assign fillIf.valid = snoopHit | fwValid | dmaValid;
  assign fillIf.item  = snoopHit ? crc_engine_pkg::item_t'{size: `BLK_32, data: snoopWord}
                      : fwValid  ? fwItem
                      : crc_engine_pkg::item_t'{size: `BLK_32, data: dmaData};

  // setup stalls the drain so no word mixes with the old configuration
  assign drainIf.ready = ~setupValid & ~polyValid;

  wire        drainFire = drainIf.valid & drainIf.ready;
  wire [1:0]  blkSize   = drainIf.item.size;
  wire [31:0] rawData   = drainIf.item.data;

  // byte swap acts only on the bytes that belong to the block
  function automatic logic [31:0] swapBytes(input logic [31:0] d, input logic [1:0] sz);
    logic [31:0] r;
    r = d;
    if (sz == `BLK_32) begin
      r = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end else if (sz == `BLK_16) begin
      r = {16'h0000, d[7:0], d[15:8]};
    end
    return r;
  endfunction : swapBytes

  function automatic logic [31:0] revInBytes(input logic [31:0] d);
    logic [31:0] r;
    r = '0;
    for (int b = 0; b < 4; b++) begin
      for (int i = 0; i < 8; i++) begin
        r[8*b+i] = d[8*b+7-i];
      end
    end
    return r;
  endfunction : revInBytes

  // unrolled: every bit of the block is folded in within one cycle
  function automatic logic [31:0] crcFold(input logic [31:0] c, input logic [31:0] d,
                                          input logic [1:0] sz, input logic w,
                                          input logic [15:0] p16);
    logic [31:0] r;
    logic        fb;
    logic [5:0]  nb;
    r  = c;
    fb = 1'b0;
    nb = (sz == `BLK_32) ? 6'h20 : (sz == `BLK_16) ? 6'h10 : 6'h08;
    for (int i = 31; i >= 0; i--) begin
      if (6'(i) < nb) begin
        fb = d[i] ^ (w ? r[31] : r[15]);
        r  = {r[30:0], 1'b0};
        if (fb) begin
          r = r ^ (w ? `CRC_POLY32 : {16'h0000, p16});
        end
        if (!w) begin
          r[31:16] = 16'h0000;
        end
      end
    end
    return r;
  endfunction : crcFold

  wire [31:0] swapped = byteSwap ? swapBytes(rawData, blkSize) : rawData;
  wire [31:0] ordered = bitRevIn ? revInBytes(swapped) : swapped;

  always_comb begin
    crc_next = crc_reg;
    if (setupValid) begin
      crc_next = setupCtrl[`CTL_WIDE] ? setupSeed : {16'h0000, setupSeed[15:0]};
    end else if (drainFire) begin
      crc_next = crcFold(crc_reg, ordered, blkSize, wide, poly_reg);
    end
  end

  // result view applies the selected bit reversal to the remainder; reading it has no side effect
  function automatic logic [31:0] viewResult(input logic [31:0] c, input logic [1:0] m);
    logic [31:0] r;
    r = c;
    if (m == `RESREV_WORD) begin
      for (int i = 0; i < 32; i++) begin
        r[i] = c[31-i];
      end
    end else if (m == `RESREV_HALF) begin
      for (int i = 0; i < 16; i++) begin
        r[i]    = c[15-i];
        r[16+i] = c[31-i];
      end
    end
    return r;
  endfunction : viewResult

  wire [15:0] ctrl_next = setupValid ? setupCtrl : ctrl_reg;
  wire [1:0]  rev_next  = ctrl_next[`CTL_RESREV_MSB:`CTL_RESREV_LSB];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_reg  <= `CRC_SEED_RESET;
      ctrl_reg <= `CTL_RESET;
      poly_reg <= `CRC_POLY16_RESET;
      lost_reg <= 1'b0;
      result   <= `CRC_SEED_RESET;
    end else begin
      crc_reg  <= crc_next;
      ctrl_reg <= ctrl_next;
      lost_reg <= snoopHit & ~fillIf.ready;
      result   <= viewResult(crc_next, rev_next);
      if (polyValid) begin
        poly_reg <= polyWord;
      end
    end
  end

  assign ctrlState = ctrl_reg;
  assign busy      = drainIf.valid;
  assign snoopLost = lost_reg;
endmodule : crc_engine

/* crc_engine_checker.sv */
// Purpose: port-level properties of the checksum engine
// Assumes: one clock, resetn async active low
// Notes:   hit repeats the snoop match from ctrlState and the bus
`timescale 1ns/100ps
module crc_engine_checker (
  input wire logic        clk,         // clock
  input wire logic        resetn,      // reset
  input wire logic        setupValid,  // setup
  input wire logic [15:0] setupCtrl,   // ctrl in
  input wire logic [31:0] setupSeed,   // seed
  input wire logic        fwValid,     // fw valid
  input wire logic        fwReady,     // fw ready
  input wire logic        dmaValid,    // dma valid
  input wire logic        dmaReady,    // dma ready
  input wire logic        snoopSel,    // sel
  input wire logic        snoopEnable, // enable
  input wire logic        snoopReady,  // ready
  input wire logic        snoopWrite,  // dir
  input wire logic [31:0] snoopAddr,   // addr
  input wire logic [31:0] result,      // result
  input wire logic [15:0] ctrlState,   // ctrl
  input wire logic        busy,        // pending
  input wire logic        snoopLost    // dropped
);
  wire logic hit = ctrlState[5] & snoopSel & snoopEnable & snoopReady
    & (snoopAddr[19:12] == ctrlState[15:8]) & (snoopWrite ? ctrlState[6] : ctrlState[7]);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  seed_load_a:
    assert property (setupValid && setupCtrl[4:0] == 5'h01 |=> result == $past(setupSeed))
    else $error("seed not shown after setup");
  ctrl_load_a:
    assert property (setupValid |=> ctrlState == $past(setupCtrl)) else $error("ctrl not loaded");
  result_hold_a:
    assert property (!busy && !setupValid |=> $stable(result)) else $error("result moved idle");
  fw_take_a:
    assert property (fwValid && !busy && !hit |-> fwReady) else $error("fw refused when empty");
  dma_take_a:
    assert property (dmaValid && !fwValid && !busy && !hit |-> dmaReady)
    else $error("dma refused when empty");
  snoop_first_a:
    assert property (hit |-> !fwReady && !dmaReady) else $error("snoop not first");
  word_rate_a:
    assert property ((fwValid && fwReady && !busy) ##1 fwValid |-> hit || fwReady)
    else $error("second word stalled");
  lost_cause_a:
    assert property (snoopLost |-> $past(hit) && $past(busy)) else $error("loss without hit");
  cover property (hit);
  cover property (snoopLost);
  cover property (fwValid && fwReady ##1 fwValid && fwReady);
endmodule : crc_engine_checker

bind crc_engine crc_engine_checker u_crc_engine_checker (.clk(clk), .resetn(resetn),
  .setupValid(setupValid), .setupCtrl(setupCtrl), .setupSeed(setupSeed), .fwValid(fwValid),
  .fwReady(fwReady), .dmaValid(dmaValid), .dmaReady(dmaReady), .snoopSel(snoopSel),
  .snoopEnable(snoopEnable), .snoopReady(snoopReady), .snoopWrite(snoopWrite),
  .snoopAddr(snoopAddr), .result(result), .ctrlState(ctrlState), .busy(busy),
  .snoopLost(snoopLost));

/* snoop_bus_model.sv */
// Purpose: peripheral bus agent whose transfers the engine watches
// Assumes: two-phase transfer, ready may lag for wait states
// Notes:   idle address and data lines show the inverse of their last value; sel, en and rdy return low
`timescale 1ns/100ps
module snoop_bus_model (
  input  wire logic        clk,   // clock
  output logic             sel,   // select
  output logic             en,    // enable
  output logic             rdy,   // ready
  output logic             wr,    // direction
  output logic      [31:0] addr,  // address
  output logic      [31:0] wdata, // write data
  output logic      [31:0] rdata  // read data
);
  initial {sel, en, rdy, wr, addr, wdata, rdata} = 100'h0;
  // idle inversion keeps a stale word from looking like a fresh match
  task automatic xfer(input logic w, input logic [31:0] a, d, input int waits);
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= w ? d : ~d;
    rdata <= w ? ~d : d;
    @(posedge clk);
    en <= 1'b1;
    repeat (waits) @(posedge clk);
    rdy <= 1'b1;
    @(posedge clk);
    {sel, en, rdy} <= 3'h0;
    addr <= ~a;
    wdata <= ~wdata;
    rdata <= ~rdata;
  endtask : xfer
endmodule : snoop_bus_model

/* tb_crc_engine.sv */
// Purpose: self-checking bench for the checksum engine
// Assumes: 10 MHz clock, reset held three cycles
// Notes:   expectations come from a bit-serial reference fold
`timescale 1ns/100ps
module tb_crc_engine;
  typedef struct packed {logic [15:0] k; logic [31:0] s; logic [1:0] sz; logic [31:0] d;} row_t;
  logic clk = 1'b0, resetn = 1'b0, setupValid = 1'b0, polyValid = 1'b0;
  logic fwValid = 1'b0, dmaValid = 1'b0, fwReady, dmaReady, busy, snoopLost, sel, en, rdy, wr;
  logic [15:0] setupCtrl = 16'h0000, polyWord = 16'h0000, ctrlState, ctl, p16 = 16'h1021;
  logic [31:0] setupSeed = 32'h0, dmaData = 32'h0, result, addr, wdata, rdata, crc;
  crc_engine_pkg::item_t fwItem = '0;
  int n_errors = 0, tests_run = 0, lost = 0;
  time t0;
  row_t rows [6] = '{'{16'h0001, 32'hFFFFFFFF, 2'h2, 32'h12345678},
    '{16'h0007, 32'h0, 2'h2, 32'hA5C30F11}, '{16'h000B, 32'hFFFFFFFF, 2'h0, 32'hC5},
    '{16'h0011, 32'h89ABCDEF, 2'h1, 32'hBEEF}, '{16'h0004, 32'hFFFF, 2'h1, 32'h1234},
    '{16'h0002, 32'h1D0F, 2'h0, 32'h31}};
  crc_engine u_crc_engine (.clk(clk), .resetn(resetn), .setupValid(setupValid),
    .setupCtrl(setupCtrl), .setupSeed(setupSeed), .polyValid(polyValid), .polyWord(polyWord),
    .fwValid(fwValid), .fwItem(fwItem), .fwReady(fwReady), .dmaValid(dmaValid),
    .dmaData(dmaData), .dmaReady(dmaReady), .snoopSel(sel), .snoopEnable(en),
    .snoopReady(rdy), .snoopWrite(wr), .snoopAddr(addr), .snoopWdata(wdata),
    .snoopRdata(rdata), .result(result), .ctrlState(ctrlState), .busy(busy),
    .snoopLost(snoopLost));
  snoop_bus_model u_snoop_bus_model (.clk(clk), .sel(sel), .en(en), .rdy(rdy), .wr(wr),
    .addr(addr), .wdata(wdata), .rdata(rdata));
  always #50 clk = ~clk;
  always @(negedge clk) lost += (snoopLost === 1'b1);
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [15:0] k,
                                       input logic [1:0] sz, input logic [31:0] d);
    logic [31:0] x;
    for (int i = 0; i < 32; i++) x[i] = k[1] ? d[i ^ 7] : d[i];
    if (k[2] && sz == 2'h2) x = {x[7:0], x[15:8], x[23:16], x[31:24]};
    if (k[2] && sz == 2'h1) x = {16'h0, x[7:0], x[15:8]};
    for (int i = (8 << sz) - 1; i >= 0; i--)
      if (k[0]) c = {c[30:0], 1'b0} ^ ((c[31] ^ x[i]) ? 32'h04C11DB7 : 32'h0);
      else c = {16'h0, c[14:0], 1'b0} ^ ((c[15] ^ x[i]) ? {16'h0, p16} : 32'h0);
    return c;
  endfunction : fold
  function automatic logic [31:0] view(input logic [31:0] c, input logic [15:0] k);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = k[4:3] == 2'h1 ? c[31 - i] : k[4:3] == 2'h2 ? c[i ^ 15] : c[i];
    return k[0] ? r : r & 32'hFFFF;
  endfunction : view
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic timeout(input string what);
    n_errors++;
    $display("ERROR wait %s expected done seen stuck", what);
    end_of_test();
  endtask : timeout
  task automatic setup(input logic [15:0] k, input logic [31:0] s);
    setupValid <= 1'b1;
    setupCtrl <= k;
    setupSeed <= s;
    @(posedge clk);
    setupValid <= 1'b0;
    ctl = k;
    crc = k[0] ? s : {16'h0, s[15:0]};
    @(negedge clk);
    check("seed view", view(crc, ctl), result & view(32'hFFFFFFFF, ctl));
    @(posedge clk);
  endtask : setup
  task automatic put(input logic dma, input logic [1:0] sz, input logic [31:0] d);
    int i;
    fwValid <= !dma;
    dmaValid <= dma;
    fwItem <= {sz, d};
    dmaData <= d;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if ((dma ? dmaReady : fwReady) === 1'b1) break;
    end
    if (i == 20) timeout("ready");
    @(posedge clk);
    crc = fold(crc, ctl, sz, d);
  endtask : put
  task automatic drain(input string what);
    int i;
    fwValid <= 1'b0;
    dmaValid <= 1'b0;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
    end
    if (i == 20) timeout("busy");
    check(what, view(crc, ctl), result & view(32'hFFFFFFFF, ctl));
    @(posedge clk);
  endtask : drain
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("reset result", 32'hFFFFFFFF, result);
    check("reset ctrl", 32'h1, {16'h0, ctrlState});
    @(posedge clk);
    resetn <= 1'b1;
    polyValid <= 1'b1;
    polyWord <= 16'h8005;
    p16 = 16'h8005;
    @(posedge clk);
    polyValid <= 1'b0;
    foreach (rows[r]) begin
      setup(rows[r].k, rows[r].s);
      put(1'b0, rows[r].sz, rows[r].d);
      drain("row result");
    end
    setup(16'h0001, 32'hFFFFFFFF);
    t0 = $time;
    for (int i = 0; i < 8; i++) put(1'b0, 2'h2, 32'h11111111 * i);
    check("burst time", 32'h320, 32'($time - t0));
    drain("burst result");
    put(1'b1, 2'h2, 32'hCAFEF00D);
    drain("dma result");
    setup(16'h3AE1, 32'hFFFFFFFF);
    u_snoop_bus_model.xfer(1'b1, 32'h4003A010, 32'h600DF00D, 0);
    u_snoop_bus_model.xfer(1'b0, 32'h4003A020, 32'h0BADCAFE, 2);
    u_snoop_bus_model.xfer(1'b1, 32'h4003B000, 32'h77777777, 1);
    crc = fold(fold(crc, ctl, 2'h2, 32'h600DF00D), ctl, 2'h2, 32'h0BADCAFE);
    drain("snoop result");
    setup(16'h3A61, 32'h0);
    // a held polynomial write stalls the drain so the buffer fills
    polyValid <= 1'b1;
    for (int i = 0; i < 3; i++) u_snoop_bus_model.xfer(1'b1, 32'h4003A000, 32'hA0000000 + i, 0);
    crc = fold(fold(crc, ctl, 2'h2, 32'hA0000000), ctl, 2'h2, 32'hA0000001);
    fwValid <= 1'b1;
    @(negedge clk);
    check("full fwReady", 32'h0, {31'h0, fwReady});
    @(posedge clk);
    polyValid <= 1'b0;
    // the loss counter ticks on the same negedge as the check above, so look one edge later
    check("lost count", 32'h1, 32'(lost));
    put(1'b0, 2'h2, 32'h5A5A5A5A);
    drain("full result");
    resetn <= 1'b0;
    @(negedge clk);
    check("midrun result", 32'hFFFFFFFF, result);
    check("midrun ctrl", 32'h1, {16'h0, ctrlState});
    check("midrun busy", 32'h0, {31'h0, busy});
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    end_of_test();
  end
endmodule : tb_crc_engine
